// >>> core/bcf_map.svh
// Constants for the bidirectional queue port control block
`ifndef BCF_MAP_SVH
`define BCF_MAP_SVH

`define BCF_DATA_W 36
`define BCF_BYTE_W 9
`define BCF_BYTES 4
`define BCF_ADDR_W 6
`define BCF_PTR_W 7
`define BCF_DEPTH_N 64
`define BCF_DEPTH 7'h40

`define BCF_SIZE_BYTE 2'h1
`define BCF_SIZE_WORD 2'h2
`define BCF_SIZE_MBX 2'h3
`define BCF_MASK_BYTE 4'h1
`define BCF_MASK_WORD 4'h3
`define BCF_MASK_ALL 4'hf

`define BCF_STRAP_WAIT 2'h2

`define BCF_BUS_ADDR_W 4
`define BCF_OFF_STATUS 4'h0
`define BCF_OFF_CTRL 4'h4
`define BCF_OFF_LEVEL 4'h8
`define BCF_CTRL_RESET 1'b1

`endif

// >>> core/bcf_pkg.sv
// Types for the bidirectional queue port control block
`include "bcf_map.svh"

package bcf_pkg;

  typedef struct packed {
    logic clk;
    logic sel_n;
    logic en;
    logic wr;
    logic mbx;
    logic pg;
    logic [`BCF_DATA_W-1:0] data;
  } bcf_a_pins_t;

  typedef struct packed {
    logic clk;
    logic sel_n;
    logic en;
    logic wr;
    logic [1:0] size;
    logic pg;
    logic [`BCF_DATA_W-1:0] data;
  } bcf_b_pins_t;

  typedef struct packed {
    logic odd;
    logic [1:0] fs;
  } bcf_c_pins_t;

  typedef struct packed {
    bcf_a_pins_t a_pins1;
    bcf_a_pins_t a_pins2;
    bcf_b_pins_t b_pins1;
    bcf_b_pins_t b_pins2;
    bcf_c_pins_t c_pins1;
    bcf_c_pins_t c_pins2;
    logic a_clk_prev;
    logic b_clk_prev;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] offset_sel;
    logic [`BCF_PTR_W-1:0] ab_wr;
    logic [`BCF_PTR_W-1:0] ab_rd;
    logic [`BCF_PTR_W-1:0] ba_wr;
    logic [`BCF_PTR_W-1:0] ba_rd;
    logic a_empty_pipe;
    logic a_empty_n;
    logic a_full_pipe;
    logic a_full_n;
    logic b_empty_pipe;
    logic b_empty_n;
    logic b_full_pipe;
    logic b_full_n;
    logic ab_flag_n;
    logic ba_flag_n;
    logic [`BCF_DATA_W-1:0] ab_mbx;
    logic [`BCF_DATA_W-1:0] ba_mbx;
    logic [`BCF_DATA_W-1:0] a_qout;
    logic [`BCF_DATA_W-1:0] b_qout;
    logic [`BCF_DATA_W-1:0] a_dout;
    logic [`BCF_DATA_W-1:0] b_dout;
    logic a_oe;
    logic b_oe;
    logic a_perr_n;
    logic b_perr_n;
    logic check_en;
    logic waitreq;
    logic [31:0] rdata;
  } bcf_state_t;

  localparam bcf_state_t BCF_STATE_RESET = '{
    ab_flag_n: 1'b1,
    ba_flag_n: 1'b1,
    a_perr_n: 1'b1,
    b_perr_n: 1'b1,
    waitreq: 1'b1,
    check_en: `BCF_CTRL_RESET,
    default: '0
  };

endpackage

// >>> core/bcf_port_control.sv
// Port control of a two-way queue pair with mailboxes, flags and parity
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "bcf_map.svh"

// What this block does
// - Port B transfers only while its select is low; outputs float otherwise
// - Port A empty flag low while B-to-A queue empty; reads blocked then
// - Port A empty low at reset, rises second port A edge after load
// - Port B empty flag low while A-to-B queue empty; reads blocked then
// - Port B empty low at reset, rises second port B edge after load
// - Port A transfers only on port A edges with enable high
// - Port B transfers only on port B edges with enable high
// - Port A full flag low while A-to-B queue full; writes blocked then
// - Port A full low at reset, rises second port A edge after reset
// - Port B full flag low while B-to-A queue full; writes blocked then
// - Port B full low at reset, rises second port B edge after reset
// - Offset select inputs are captured when reset ends
// - Port A mailbox select chooses mailbox, else queue output register
// - Port A mailbox write drops A-to-B flag; further writes ignored
// - A-to-B flag rises on port B mailbox read; reset sets it
// - Port B mailbox write drops B-to-A flag; further writes ignored
// - B-to-A flag rises on port A mailbox read; reset sets it
// - Parity sense input picks odd or even for checking and generation
// - Port A error low when any of four input bytes fails parity
// - Port B error low when a byte valid for current size fails
// - Port A error forced high during mailbox read with generation
// - Port B error forced high during mailbox read with generation
// - Write/read select high means write and floats that port's outputs
// - With generation on, reads carry generated parity in each byte top
// - Both port B size selects high route port B access to mailbox
module bcf_port_control
  import bcf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_port_a_clock,
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_enable,
  input wire logic i_port_a_write_read,
  input wire logic i_port_a_mailbox_select,
  input wire logic i_port_a_parity_generate,
  input wire logic [`BCF_DATA_W-1:0] i_port_a_data,
  output logic [`BCF_DATA_W-1:0] o_port_a_data,
  output logic o_port_a_data_oe,
  output logic o_port_a_empty_n,
  output logic o_port_a_full_n,
  output logic o_port_a_parity_error_n,
  input wire logic i_port_b_clock,
  input wire logic i_port_b_select_n,
  input wire logic i_port_b_enable,
  input wire logic i_port_b_write_read,
  input wire logic [1:0] i_port_b_size_select,
  input wire logic i_port_b_parity_generate,
  input wire logic [`BCF_DATA_W-1:0] i_port_b_data,
  output logic [`BCF_DATA_W-1:0] o_port_b_data,
  output logic o_port_b_data_oe,
  output logic o_port_b_empty_n,
  output logic o_port_b_full_n,
  output logic o_port_b_parity_error_n,
  input wire logic i_parity_odd,
  input wire logic [1:0] i_offset_select,
  output logic o_a_to_b_mailbox_flag_n,
  output logic o_b_to_a_mailbox_flag_n,
  input wire logic [`BCF_BUS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  bcf_state_t st_reg;
  bcf_state_t st_next;
  logic [`BCF_DATA_W-1:0] ab_mem [0:`BCF_DEPTH_N-1];
  logic [`BCF_DATA_W-1:0] ba_mem [0:`BCF_DEPTH_N-1];

  bcf_a_pins_t a2;
  bcf_b_pins_t b2;
  logic a_edge;
  logic b_edge;
  logic a_act;
  logic b_act;
  logic b_mbx_path;
  logic a_q_wr;
  logic a_q_rd;
  logic a_mbx_wr;
  logic a_mbx_rd;
  logic b_q_wr;
  logic b_q_rd;
  logic b_mbx_wr;
  logic b_mbx_rd;
  logic [`BCF_PTR_W-1:0] ab_cnt;
  logic [`BCF_PTR_W-1:0] ba_cnt;
  logic [`BCF_PTR_W-1:0] ab_after_a;
  logic [`BCF_PTR_W-1:0] ba_after_a;
  logic [`BCF_PTR_W-1:0] ab_after_b;
  logic [`BCF_PTR_W-1:0] ba_after_b;
  logic [`BCF_DATA_W-1:0] a_raw;
  logic [`BCF_DATA_W-1:0] b_raw;
  logic [31:0] rd_value;

  function automatic logic [`BCF_BYTES-1:0] size_mask(input logic [1:0] size);
    case (size)
      `BCF_SIZE_BYTE: size_mask = `BCF_MASK_BYTE;
      `BCF_SIZE_WORD: size_mask = `BCF_MASK_WORD;
      default: size_mask = `BCF_MASK_ALL;
    endcase
  endfunction

  function automatic logic parity_fail(input logic [`BCF_DATA_W-1:0] d, input logic odd,
                                       input logic [`BCF_BYTES-1:0] mask);
    logic f;
    f = 1'b0;
    for (int i = 0; i < `BCF_BYTES; i++) begin
      if (mask[i] && ((^d[i*`BCF_BYTE_W +: `BCF_BYTE_W]) != odd)) begin
        f = 1'b1;
      end
    end
    return f;
  endfunction

  // Top bit of each byte replaced so the whole byte meets the chosen sense
  function automatic logic [`BCF_DATA_W-1:0] parity_gen(input logic [`BCF_DATA_W-1:0] d,
                                                        input logic odd);
    logic [`BCF_DATA_W-1:0] r;
    r = d;
    for (int i = 0; i < `BCF_BYTES; i++) begin
      r[i*`BCF_BYTE_W + `BCF_BYTE_W - 1] = (^d[i*`BCF_BYTE_W +: `BCF_BYTE_W-1]) ^ odd;
    end
    return r;
  endfunction

  function automatic logic [`BCF_PTR_W-1:0] bump(input logic [`BCF_PTR_W-1:0] p,
                                                 input logic en);
    return p + {6'h00, en};
  endfunction

  function automatic logic [`BCF_PTR_W-1:0] drop(input logic [`BCF_PTR_W-1:0] p,
                                                 input logic en);
    return p - {6'h00, en};
  endfunction

  assign a2 = st_reg.a_pins2;
  assign b2 = st_reg.b_pins2;
  // Port clocks are sampled pins; an edge is a one-cycle enable
  // Edges wait for the strap window so a clock already high at release is no false edge
  assign a_edge = a2.clk & ~st_reg.a_clk_prev & st_reg.strap_done;
  assign b_edge = b2.clk & ~st_reg.b_clk_prev & st_reg.strap_done;
  assign a_act = a_edge & ~a2.sel_n & a2.en;
  assign b_act = b_edge & ~b2.sel_n & b2.en;
  assign b_mbx_path = (b2.size == `BCF_SIZE_MBX);
  assign a_q_wr = a_act & a2.wr & ~a2.mbx & st_reg.a_full_n;
  assign a_q_rd = a_act & ~a2.wr & ~a2.mbx & st_reg.a_empty_n;
  assign a_mbx_wr = a_act & a2.wr & a2.mbx & st_reg.ab_flag_n;
  assign a_mbx_rd = a_act & ~a2.wr & a2.mbx;
  assign b_q_wr = b_act & b2.wr & ~b_mbx_path & st_reg.b_full_n;
  assign b_q_rd = b_act & ~b2.wr & ~b_mbx_path & st_reg.b_empty_n;
  assign b_mbx_wr = b_act & b2.wr & b_mbx_path & st_reg.ba_flag_n;
  assign b_mbx_rd = b_act & ~b2.wr & b_mbx_path;
  assign ab_cnt = st_reg.ab_wr - st_reg.ab_rd;
  assign ba_cnt = st_reg.ba_wr - st_reg.ba_rd;
  // Each side ignores the far side's move this cycle, so flags err safe
  assign ab_after_a = bump(ab_cnt, a_q_wr);
  assign ba_after_a = drop(ba_cnt, a_q_rd);
  assign ab_after_b = drop(ab_cnt, b_q_rd);
  assign ba_after_b = bump(ba_cnt, b_q_wr);

  always_comb begin
    case (i_avs_address)
      `BCF_OFF_STATUS: rd_value = {22'h00_0000, st_reg.offset_sel, st_reg.b_perr_n,
                                   st_reg.a_perr_n, st_reg.ba_flag_n, st_reg.ab_flag_n,
                                   st_reg.b_full_n, st_reg.b_empty_n, st_reg.a_full_n,
                                   st_reg.a_empty_n};
      `BCF_OFF_CTRL: rd_value = {31'h0000_0000, st_reg.check_en};
      `BCF_OFF_LEVEL: rd_value = {9'h000, ba_cnt, 9'h000, ab_cnt};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.a_pins1 = {i_port_a_clock, i_port_a_select_n, i_port_a_enable,
                       i_port_a_write_read, i_port_a_mailbox_select,
                       i_port_a_parity_generate, i_port_a_data};
    st_next.b_pins1 = {i_port_b_clock, i_port_b_select_n, i_port_b_enable,
                       i_port_b_write_read, i_port_b_size_select,
                       i_port_b_parity_generate, i_port_b_data};
    st_next.c_pins1 = {i_parity_odd, i_offset_select};
    st_next.a_pins2 = st_reg.a_pins1;
    st_next.b_pins2 = st_reg.b_pins1;
    st_next.c_pins2 = st_reg.c_pins1;
    st_next.a_clk_prev = a2.clk;
    st_next.b_clk_prev = b2.clk;

    // Wait until the synchronisers hold post-release values before latching
    if (!st_reg.strap_done) begin
      st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
      if (st_reg.strap_cnt == `BCF_STRAP_WAIT) begin
        st_next.offset_sel = st_reg.c_pins2.fs;
        st_next.strap_done = 1'b1;
      end
    end

    st_next.ab_wr = bump(st_reg.ab_wr, a_q_wr);
    st_next.ab_rd = bump(st_reg.ab_rd, b_q_rd);
    st_next.ba_wr = bump(st_reg.ba_wr, b_q_wr);
    st_next.ba_rd = bump(st_reg.ba_rd, a_q_rd);

    // Two-stage flags: empty sees a load on the second port edge and a drain at once; full sees a load at once, a drain on the second edge
    if (a_edge) begin
      st_next.a_empty_pipe = (ba_after_a != '0);
      st_next.a_empty_n = st_reg.a_empty_pipe && (ba_after_a != '0);
      st_next.a_full_pipe = (ab_after_a != `BCF_DEPTH);
      st_next.a_full_n = st_reg.a_full_pipe && (ab_after_a != `BCF_DEPTH);
    end
    if (b_edge) begin
      st_next.b_empty_pipe = (ab_after_b != '0);
      st_next.b_empty_n = st_reg.b_empty_pipe && (ab_after_b != '0);
      st_next.b_full_pipe = (ba_after_b != `BCF_DEPTH);
      st_next.b_full_n = st_reg.b_full_pipe && (ba_after_b != `BCF_DEPTH);
    end

    if (a_q_rd) begin
      st_next.a_qout = ba_mem[st_reg.ba_rd[`BCF_ADDR_W-1:0]];
    end
    if (b_q_rd) begin
      st_next.b_qout = ab_mem[st_reg.ab_rd[`BCF_ADDR_W-1:0]];
    end

    // Mailbox write is applied after the read so new mail is never lost
    if (b_mbx_rd) begin
      st_next.ab_flag_n = 1'b1;
    end
    if (a_mbx_wr) begin
      st_next.ab_mbx = a2.data;
      st_next.ab_flag_n = 1'b0;
    end
    if (a_mbx_rd) begin
      st_next.ba_flag_n = 1'b1;
    end
    if (b_mbx_wr) begin
      st_next.ba_mbx = b2.data;
      st_next.ba_flag_n = 1'b0;
    end

    a_raw = a2.mbx ? st_next.ba_mbx : st_next.a_qout;
    b_raw = b_mbx_path ? st_next.ab_mbx : st_next.b_qout;
    st_next.a_dout = a2.pg ? parity_gen(a_raw, st_reg.c_pins2.odd) : a_raw;
    st_next.b_dout = b2.pg ? parity_gen(b_raw, st_reg.c_pins2.odd) : b_raw;
    st_next.a_oe = ~a2.sel_n & ~a2.wr;
    st_next.b_oe = ~b2.sel_n & ~b2.wr;

    // Parity trees are shared with generation, so a generating mailbox read hides errors
    st_next.a_perr_n = (~a2.wr & a2.mbx & a2.pg) |
                       ~(st_reg.check_en &
                         parity_fail(a2.data, st_reg.c_pins2.odd, `BCF_MASK_ALL));
    st_next.b_perr_n = (~b2.wr & b_mbx_path & b2.pg) |
                       ~(st_reg.check_en &
                         parity_fail(b2.data, st_reg.c_pins2.odd, size_mask(b2.size)));

    // One wait cycle: raised by default, dropped once per request
    st_next.waitreq = ~((i_avs_read | i_avs_write) & st_reg.waitreq);
    if (i_avs_read && st_reg.waitreq) begin
      st_next.rdata = rd_value;
    end
    if (i_avs_write && !st_reg.waitreq && (i_avs_address == `BCF_OFF_CTRL) &&
        i_avs_byteenable[0]) begin
      st_next.check_en = i_avs_writedata[0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= BCF_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage has no reset; the pointers alone decide what is valid
  always_ff @(posedge i_clock) begin
    if (a_q_wr) begin
      ab_mem[st_reg.ab_wr[`BCF_ADDR_W-1:0]] <= a2.data;
    end
    if (b_q_wr) begin
      ba_mem[st_reg.ba_wr[`BCF_ADDR_W-1:0]] <= b2.data;
    end
  end

  assign o_port_a_data = st_reg.a_dout;
  assign o_port_a_data_oe = st_reg.a_oe;
  assign o_port_a_empty_n = st_reg.a_empty_n;
  assign o_port_a_full_n = st_reg.a_full_n;
  assign o_port_a_parity_error_n = st_reg.a_perr_n;
  assign o_port_b_data = st_reg.b_dout;
  assign o_port_b_data_oe = st_reg.b_oe;
  assign o_port_b_empty_n = st_reg.b_empty_n;
  assign o_port_b_full_n = st_reg.b_full_n;
  assign o_port_b_parity_error_n = st_reg.b_perr_n;
  assign o_a_to_b_mailbox_flag_n = st_reg.ab_flag_n;
  assign o_b_to_a_mailbox_flag_n = st_reg.ba_flag_n;
  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = st_reg.waitreq;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_B_FLOAT_DESELECTED: assert property (b2.sel_n |=> !o_port_b_data_oe)
    else $error("port B drives data while deselected");
  AST_A_EMPTY_HOLDS_READS: assert property (!o_port_a_empty_n |=> $stable(st_reg.ba_rd))
    else $error("B-to-A queue read while port A shows empty");
  AST_A_EMPTY_ON_EDGE: assert property (!a_edge |=> $stable(o_port_a_empty_n))
    else $error("port A empty flag moved without a port A edge");
  AST_A_EMPTY_TWO_EDGES: assert property (a_edge && !st_reg.a_empty_pipe |=> !o_port_a_empty_n)
    else $error("port A empty flag rose before the second edge");
  AST_B_EMPTY_TWO_EDGES: assert property (b_edge && !st_reg.b_empty_pipe |=> !o_port_b_empty_n)
    else $error("port B empty flag rose before the second edge");
  AST_A_DISABLED_STILL: assert property (!a2.en |=> $stable(st_reg.ab_wr) && $stable(st_reg.ba_rd))
    else $error("port A queue moved with enable low");
  AST_B_DISABLED_STILL: assert property (!b2.en |=> $stable(st_reg.ba_wr) && $stable(st_reg.ab_rd))
    else $error("port B queue moved with enable low");
  AST_A_FULL_WHEN_FULL: assert property (ab_cnt == `BCF_DEPTH |-> !o_port_a_full_n)
    else $error("port A full flag high with A-to-B queue full");
  AST_B_FULL_WHEN_FULL: assert property (ba_cnt == `BCF_DEPTH |-> !o_port_b_full_n)
    else $error("port B full flag high with B-to-A queue full");
  AST_B_FULL_TWO_EDGES: assert property (b_edge && !st_reg.b_full_pipe |=> !o_port_b_full_n)
    else $error("port B full flag rose before the second edge");
  AST_AB_MAIL_LOCKED: assert property (!o_a_to_b_mailbox_flag_n |=> $stable(st_reg.ab_mbx))
    else $error("A-to-B mailbox overwritten while flag low");
  AST_AB_MAIL_RELEASE: assert property (b_mbx_rd && !a_mbx_wr |=> o_a_to_b_mailbox_flag_n)
    else $error("A-to-B flag not raised by port B mailbox read");
  AST_BA_MAIL_RELEASE: assert property (a_mbx_rd && !b_mbx_wr |=> o_b_to_a_mailbox_flag_n)
    else $error("B-to-A flag not raised by port A mailbox read");
  AST_A_PERR_FORCED: assert property (!a2.wr && a2.mbx && a2.pg |=> o_port_a_parity_error_n)
    else $error("port A parity error shown during generating mailbox read");
  AST_B_PERR_FORCED: assert property (!b2.wr && b_mbx_path && b2.pg |=> o_port_b_parity_error_n)
    else $error("port B parity error shown during generating mailbox read");

  COV_QUEUE_A_TO_B: cover property (a_q_wr ##[1:300] b_q_rd);
  COV_QUEUE_FILLS: cover property (ab_cnt == `BCF_DEPTH);
  COV_MAIL_A_TO_B: cover property (a_mbx_wr ##[1:300] b_mbx_rd);
  COV_BUS_WRITE: cover property (i_avs_write && !o_avs_waitrequest);

endmodule

`default_nettype wire

// >>> verification/bcf_port_control_tb_top.sv
// Self-checking bench for the queue pair port control block
`timescale 1ns/10ps
`default_nettype none
module bcf_port_control_tb_top;
  localparam logic [5:0] WQ = 6'b111000;
  localparam logic [5:0] RQ = 6'b110000;
  localparam logic [5:0] MW = 6'b111110;
  localparam logic [5:0] MR = 6'b110110;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic go_a = 1'b0;
  logic go_b = 1'b0;
  logic [5:0] ctl_a = 6'h00;
  logic [5:0] ctl_b = 6'h00;
  logic [35:0] dat_a = 36'h0_0000_0000;
  logic [35:0] dat_b = 36'h0_0000_0000;
  logic parity_odd = 1'b1;
  logic [1:0] offset = 2'h0;
  logic [3:0] avs_addr = 4'h0;
  logic [3:0] avs_be = 4'hf;
  logic avs_rd = 1'b0;
  logic avs_wr = 1'b0;
  logic [31:0] avs_wdata = 32'h0000_0000;
  logic [31:0] seed = 32'h0292_a4dc;
  logic [31:0] rd;
  logic [35:0] w;
  logic [35:0] q[$];
  logic pa, pb, oa, ob;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  wire [35:0] pin_a, pin_b, out_a, out_b;
  wire [1:0] ra, rb;
  wire [31:0] rdata;
  wire ca, sa, ea, wa, ga, da, cb, sb, eb, wb, gb, db, oea, oeb;
  wire efa, ffa, pfa, efb, ffb, pfb, mf1, mf2, wreq;

  always #50 i_clock = ~i_clock;

  bcf_port_host ha (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_go(go_a), .i_ctl(ctl_a),
    .i_data(dat_a), .o_port_clock(ca), .o_select_n(sa), .o_enable(ea), .o_write_read(wa),
    .o_route(ra), .o_pg(ga), .o_data(pin_a), .o_done(da));
  bcf_port_host hb (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_go(go_b), .i_ctl(ctl_b),
    .i_data(dat_b), .o_port_clock(cb), .o_select_n(sb), .o_enable(eb), .o_write_read(wb),
    .o_route(rb), .o_pg(gb), .o_data(pin_b), .o_done(db));
  bcf_port_control dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_port_a_clock(ca),
    .i_port_a_select_n(sa), .i_port_a_enable(ea), .i_port_a_write_read(wa),
    .i_port_a_mailbox_select(ra[0]), .i_port_a_parity_generate(ga), .i_port_a_data(pin_a),
    .o_port_a_data(out_a), .o_port_a_data_oe(oea), .o_port_a_empty_n(efa),
    .o_port_a_full_n(ffa), .o_port_a_parity_error_n(pfa), .i_port_b_clock(cb),
    .i_port_b_select_n(sb), .i_port_b_enable(eb), .i_port_b_write_read(wb),
    .i_port_b_size_select(rb), .i_port_b_parity_generate(gb), .i_port_b_data(pin_b),
    .o_port_b_data(out_b), .o_port_b_data_oe(oeb), .o_port_b_empty_n(efb),
    .o_port_b_full_n(ffb), .o_port_b_parity_error_n(pfb), .i_parity_odd(parity_odd),
    .i_offset_select(offset), .o_a_to_b_mailbox_flag_n(mf1), .o_b_to_a_mailbox_flag_n(mf2),
    .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
    .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [35:0] gen(input logic [35:0] d, input logic odd);
    gen = d;
    for (int k = 0; k < 4; k++) begin
      gen[9*k+8] = ^d[9*k +: 8] ^ odd;
    end
  endfunction

  task automatic rnd(output logic [35:0] v);
    seed = lfsr(seed);
    v = {seed[7:4], seed};
  endtask

  task automatic chk(input logic [36:0] got, input logic [36:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // One port access; error flag and drive enable are taken while pins still hold
  task automatic acc(input logic b, input logic [5:0] c, input logic [35:0] d);
    @(posedge i_clock);
    if (b) begin
      go_b <= 1'b1;
      ctl_b <= c;
      dat_b <= d;
    end else begin
      go_a <= 1'b1;
      ctl_a <= c;
      dat_a <= d;
    end
    do @(posedge i_clock); while (!(b ? db : da));
    {pa, pb, oa, ob} = {pfa, pfb, oea, oeb};
    go_a <= 1'b0;
    go_b <= 1'b0;
    repeat (5) @(posedge i_clock);
  endtask

  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd,
      input logic [3:0] be);
    @(posedge i_clock);
    avs_addr <= a;
    avs_wdata <= wd;
    avs_be <= be;
    avs_wr <= wr;
    avs_rd <= ~wr;
    do @(posedge i_clock); while (wreq !== 1'b0);
    rd = rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole plan needs about 4000 cycles; the ceiling leaves ample margin
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("mismatch at %0t: run hung", $time);
      end_of_test();
    end
  end

  initial begin
    seed = lfsr(seed);
    offset <= seed[1:0];
    @(posedge i_clock);
    @(negedge i_clock);
    chk({efa, efb, ffa, ffb, mf1, mf2, pfa, pfb}, 8'h0f, "reset flags");
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (6) @(negedge i_clock);
    chk({ffa, ffb}, 2'b00, "full early");
    repeat (40) @(posedge i_clock);
    chk({efa, efb, ffa, ffb}, 4'b0011, "full after reset");
    avs(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd[9:8], offset, "offset strap");
    avs(1'b0, 4'hc, 32'h0, 4'hf);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      rnd(w);
      q.push_back(w);
      acc(1'b0, WQ, w);
    end
    chk(ffa, 1'b0, "a full");
    acc(1'b0, WQ, 36'h5_5555_5555);
    chk({efb, oa}, 2'b10, "b not empty");
    avs(1'b0, 4'h8, 32'h0, 4'hf);
    chk(rd[6:0], 7'h40, "level");
    for (int i = 0; i < 64; i++) begin
      acc(1'b1, RQ, 36'h0);
      chk({ob, out_b}, {1'b1, q.pop_front()}, "b read");
    end
    chk({efb, ffa, oeb}, 3'b010, "b drained");
    w = out_b;
    acc(1'b1, RQ, 36'h0);
    chk(out_b, w, "blocked read");
    $display("test a_to_b queue done");
    for (int o = 0; o < 2; o++) begin
      parity_odd <= o[0];
      rnd(w);
      acc(1'b1, WQ, w);
      repeat (30) @(posedge i_clock);
      chk(efa, 1'b1, "a not empty");
      acc(1'b0, RQ | 6'h01, 36'h0);
      chk(out_a, gen(w, o[0]), "a gen read");
    end
    for (int p = 0; p < 2; p++) begin
      acc(p[0], 6'b101000, w);
      acc(p[0], 6'b011000, w);
    end
    repeat (30) @(posedge i_clock);
    chk({efa, efb}, 2'b00, "gated access");
    $display("test b_to_a and gating done");
    rnd(w);
    acc(1'b0, MW, w);
    chk(mf1, 1'b0, "mbx1 set");
    acc(1'b0, MW, ~w);
    acc(1'b1, MR, 36'h0);
    chk({mf1, out_b}, {1'b1, w}, "mbx1 read");
    rnd(w);
    acc(1'b1, MW, w);
    chk(mf2, 1'b0, "mbx2 set");
    acc(1'b0, MR, 36'h0);
    chk({mf2, out_a}, {1'b1, w}, "mbx2 read");
    $display("test mailbox done");
    for (int k = 0; k < 4; k++) begin
      rnd(w);
      w = gen(w, 1'b1) ^ (36'h1 << (9 * k));
      acc(1'b0, RQ, w);
      chk(pa, 1'b0, "a byte error");
      acc(1'b1, 6'b110010, w);
      chk(pb, k != 0, "b sized error");
    end
    acc(1'b0, RQ, gen(w, 1'b1));
    chk(pa, 1'b1, "a good parity");
    acc(1'b0, MR | 6'h01, w);
    chk(pa, 1'b1, "a gen mbx read");
    acc(1'b1, MR | 6'h01, w);
    chk(pb, 1'b1, "b gen mbx read");
    avs(1'b1, 4'h4, 32'h0, 4'hf);
    acc(1'b0, RQ, w);
    chk(pa, 1'b1, "check disabled");
    avs(1'b1, 4'h4, 32'h1, 4'hf);
    $display("test parity done");
    for (int i = 0; i < 64; i++) begin
      rnd(w);
      acc(1'b1, WQ, w);
    end
    avs(1'b0, 4'h8, 32'h0, 4'hf);
    chk({ffb, efa, rd[22:16]}, {2'b01, 7'h40}, "b_to_a full");
    $display("test b_to_a fill done");
    rnd(w);
    acc(1'b0, MW, w);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    offset <= ~offset;
    // Five port clock periods, so each port clock rises at least four times
    repeat (40) @(posedge i_clock);
    chk({efa, efb, ffa, ffb, mf1, mf2}, 6'h03, "mid reset flags");
    i_rst_n <= 1'b1;
    repeat (6) @(negedge i_clock);
    chk({ffa, ffb}, 2'b00, "full early again");
    repeat (40) @(posedge i_clock);
    chk({efa, efb, ffa, ffb, mf1}, 5'b00111, "mid reset release");
    avs(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd[9:8], offset, "offset strap again");
    $display("test reset again done");
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verification/bcf_port_host.sv
// Host model that drives one port of the queue block with its own port clock
`timescale 1ns/10ps
`default_nettype none
module bcf_port_host (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [5:0] i_ctl,
  input wire logic [35:0] i_data,
  output logic o_port_clock,
  output logic o_select_n,
  output logic o_enable,
  output logic o_write_read,
  output logic [1:0] o_route,
  output logic o_pg,
  output logic [35:0] o_data,
  output logic o_done
);
  logic [2:0] cnt = 3'h0;
  logic busy;
  // Free-running port clock, 8 system cycles a period, so each level lasts 4
  assign o_port_clock = cnt[2];
  always @(posedge i_clock) begin
    cnt <= cnt + 3'h1;
  end
  // Controls rise mid-low phase and stay put across the rising edge
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
      o_select_n <= 1'b1;
      {o_enable, o_write_read, o_route, o_pg} <= 5'h00;
      o_data <= 36'h0_0000_0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (cnt == 3'h1 && busy) begin
        busy <= 1'b0;
        o_select_n <= 1'b1;
        o_enable <= 1'b0;
        // Released lines show the inverse so stale data never looks valid
        o_data <= ~o_data;
        o_done <= 1'b1;
      end else if (cnt == 3'h1 && i_go) begin
        busy <= 1'b1;
        {o_select_n, o_enable, o_write_read, o_route, o_pg} <= {~i_ctl[5], i_ctl[4:0]};
        o_data <= i_data;
      end
    end
  end
endmodule
`default_nettype wire
